// *** logic/twr_pkg.sv ***
/*
 * Constants shared by the three-wire radio control port.
 * Assumes a single system clock domain; serial pins are synchronised inside.
 */
package twr_pkg;

   // ****************************************************************
   // Serial word framing
   // ****************************************************************
   localparam int unsigned WORD_BITS = 24;
   localparam int unsigned DATA_BITS = 21;
   localparam logic [5:0]  WORD_LEN  = 6'h18;
   localparam logic [5:0]  CNT_MAX   = 6'h3f;

   // Address positions inside the 24-bit word (index = word bit - 1)
   localparam int unsigned ADDR_TOP_POS = 23;
   localparam int unsigned ADDR_MID_POS = 1;
   localparam int unsigned ADDR_LOW_POS = 0;
   // Payload window inside the word
   localparam int unsigned PAY_HI = 22;
   localparam int unsigned PAY_LO = 2;

   // Target codes for {target_select_mid, target_select_low}
   localparam logic [1:0] TGT_STATE = 2'h0;
   localparam logic [1:0] TGT_SETUP = 2'h1;

   // ****************************************************************
   // Field positions inside the radio state word (index = word bit - 3)
   // ****************************************************************
   localparam int unsigned F_BAND        = 20;
   localparam int unsigned F_OP_HI       = 19;
   localparam int unsigned F_OP_LO       = 17;
   localparam int unsigned F_LO2_OFF     = 16;
   localparam int unsigned F_LO1_OFF     = 15;
   localparam int unsigned F_RXDIV2_OFF  = 14;
   localparam int unsigned F_TXDIV3_OFF  = 13;
   localparam int unsigned F_LPF_TUNE    = 12;
   localparam int unsigned F_PRECHARGE   = 11;
   localparam int unsigned F_CAL_SKIP    = 10;
   localparam int unsigned F_TXIF_DIVSEL = 9;
   localparam int unsigned F_TXDIV6      = 8;
   localparam int unsigned F_TXIF_CORR   = 7;
   localparam int unsigned F_GAIN_HI     = 6;
   localparam int unsigned F_GAIN_LO     = 1;
   localparam int unsigned F_LNA         = 0;

   // Position of the soft-reset bit inside the setup word
   localparam int unsigned SETUP_RESET_POS = 20;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [20:0] STATE_RST = 21'h000000;
   localparam logic [20:0] SETUP_RST = 21'h000000;

   // ****************************************************************
   // Operating states
   // ****************************************************************
   localparam logic [2:0] OP_SLEEP     = 3'h0;
   localparam logic [2:0] OP_TX_SETTLE = 3'h4;
   localparam logic [2:0] OP_RX_SETTLE = 3'h5;
   localparam logic [2:0] OP_TX_ON     = 3'h6;
   localparam logic [2:0] OP_RX_ON     = 3'h7;

endpackage : twr_pkg

// *** logic/twr_word_if.sv ***
/*
 * Carrier between the serial shifter and the register bank.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface twr_word_if;
   logic [23:0] word;
   logic [5:0]  nbits;
   logic        latch_stb;

   modport src (output word, output nbits, output latch_stb);
   modport dst (input  word, input  nbits, input  latch_stb);
endinterface : twr_word_if

// *** logic/twr_shift.sv ***
/*
 * Serial shifter: synchronises clock, data and latch pins, shifts data on
 * serial clock rising edges and presents the captured word on latch.
 * Assumes serial clock well below a quarter of the system clock.
 */
`timescale 1ns/1ps
module twr_shift (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   // Serial pins
   input  wire logic   sclk_i,
   input  wire logic   sdata_i,
   input  wire logic   latch_i,
   // Captured word
   twr_word_if.src     wrd
);

   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [1:0]  data_s;
      logic [2:0]  latch_s;
      logic [23:0] shreg;
      logic [5:0]  cnt;
      logic [23:0] word;
      logic [5:0]  nbits;
      logic        stb;
   } twr_shift_st_t;

   twr_shift_st_t st_q;
   twr_shift_st_t st_d;

   always_comb begin
      st_d         = st_q;
      st_d.sclk_s  = {st_q.sclk_s[1:0], sclk_i};
      st_d.data_s  = {st_q.data_s[0], sdata_i};
      st_d.latch_s = {st_q.latch_s[1:0], latch_i};
      st_d.stb     = 1'b0;
      // Data taken on serial clock rising edge, first bit ends up on top
      if (st_q.sclk_s[1] && !st_q.sclk_s[2]) begin
         st_d.shreg = {st_q.shreg[22:0], st_q.data_s[1]};
         if (st_q.cnt != twr_pkg::CNT_MAX) begin
            st_d.cnt = st_q.cnt + 6'h01;
         end
      end
      // Latch rise with serial clock low closes the word
      if (st_q.latch_s[1] && !st_q.latch_s[2] && !st_q.sclk_s[1]) begin
         st_d.word  = st_q.shreg;
         st_d.nbits = st_q.cnt;
         st_d.stb   = 1'b1;
         st_d.cnt   = 6'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wrd.word      = st_q.word;
   assign wrd.nbits     = st_q.nbits;
   assign wrd.latch_stb = st_q.stb;

endmodule : twr_shift

// *** logic/twr_top.sv ***
/*
 * Three-wire radio control port: decodes words latched from the shared
 * serial bus and holds the radio state word and the setup word.
 * Assumes the serial pins are driven by an external controller, asynchronous
 * to the system clock, and that other chips on the bus ignore our words.
 */

// Summary of operation
// - A valid word is exactly 24 bits: 3 address bits and 21 data.
// - Bits shift serially; whole word loads into target register on latch rise.
// - Last bit precedes latch rising; latch rises only while serial clock low.
// - Most significant bit first: word bit 24 first, bit 1 last.
// - Address at bits 24,2,1; top high with 00 radio state, 01 setup.
// - Words with top address bit low belong to the companion chip; ignored.
// - Radio state word bit 23 is band select.
// - Bits 22 to 20 form the operating-state field.
// - Bits 19 to 16 disable LO2, LO1, rx div2 and tx div3 correctors.
// - Bit 15 lowpass tune, 14 precharge only, 13 offset calibration skip.
// - Bit 12 tx IF divider, 11 divide-by-6, 10 tx IF corrector off.
// - Bits 9 to 4 gain code; bit 3 switches the LNA.
// - Setup write with reset bit high clears the whole radio state word.
// - Op state 111 entered with skip low starts offset calibration.
// - Band 0 enables low-band path, band 1 enables high-band path.
`timescale 1ns/1ps
module twr_top (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   // Three-wire serial bus
   input  wire logic        SER_CLK_I,
   input  wire logic        SER_DATA_I,
   input  wire logic        SER_LATCH_I,
   // Band and mode
   output logic             BAND_SEL_O,
   output logic             LOW_BAND_EN_O,
   output logic             HIGH_BAND_EN_O,
   output logic [2:0]       OP_STATE_O,
   // Test disables
   output logic             LO2_OFF_O,
   output logic             LO1_OFF_O,
   output logic             RX_DIV2_CORRECTOR_OFF_O,
   output logic             TX_DIV3_CORRECTOR_OFF_O,
   // Calibration
   output logic             LOWPASS_TUNE_REQUEST_O,
   output logic             OFFSET_PRECHARGE_ONLY_O,
   output logic             OFFSET_CAL_SKIP_O,
   output logic             OFFSET_CAL_START_O,
   // Transmit IF dividers
   output logic             TX_IF_DIVIDER_SELECT_O,
   output logic             TX_DIV6_SELECT_O,
   output logic             TX_IF_CORRECTOR_OFF_O,
   // Gain
   output logic [5:0]       IF_GAIN_CODE_O,
   output logic             LNA_SWITCH_O,
   // Raw registers and word status
   output logic [20:0]      RADIO_STATE_WORD_O,
   output logic [20:0]      SETUP_WORD_O,
   output logic             WORD_ACCEPT_O,
   output logic             WORD_DROP_O
);

   // ****************************************************************
   // Serial front end
   // ****************************************************************
   twr_word_if wrd ();

   twr_shift u_shift (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .sclk_i  (SER_CLK_I),
      .sdata_i (SER_DATA_I),
      .latch_i (SER_LATCH_I),
      .wrd     (wrd)
   );

   // ****************************************************************
   // Register bank state
   // ****************************************************************
   typedef struct packed {
      logic [20:0] state_word;
      logic [20:0] setup_word;
      logic        cal_start;
      logic        accept;
      logic        drop;
   } twr_top_st_t;

   twr_top_st_t st_q;
   twr_top_st_t st_d;

   logic        tgt_top;
   logic [1:0]  tgt_code;
   logic [20:0] payload;
   logic        len_ok;
   logic [2:0]  op_new;
   logic [2:0]  op_old;
   logic        enter_rx_on;
   logic        soft_clear;

   assign tgt_top  = wrd.word[twr_pkg::ADDR_TOP_POS];
   assign tgt_code = {wrd.word[twr_pkg::ADDR_MID_POS], wrd.word[twr_pkg::ADDR_LOW_POS]};
   assign payload  = wrd.word[twr_pkg::PAY_HI:twr_pkg::PAY_LO];
   // A short or long transfer would misplace every field, so it is refused
   assign len_ok   = (wrd.nbits == twr_pkg::WORD_LEN);

   // ****************************************************************
   // Field decode
   // ****************************************************************
   assign op_new      = payload[twr_pkg::F_OP_HI:twr_pkg::F_OP_LO];
   assign op_old      = st_q.state_word[twr_pkg::F_OP_HI:twr_pkg::F_OP_LO];
   // Rewriting receive-on while already there must not restart calibration
   assign enter_rx_on = (op_new == twr_pkg::OP_RX_ON)
                        && !payload[twr_pkg::F_CAL_SKIP]
                        && (op_old != twr_pkg::OP_RX_ON);
   // Soft reset request carried by a setup word
   assign soft_clear  = payload[twr_pkg::SETUP_RESET_POS];

   // ****************************************************************
   // Word decode
   // ****************************************************************
   always_comb begin
      st_d           = st_q;
      st_d.cal_start = 1'b0;
      st_d.accept    = 1'b0;
      st_d.drop      = 1'b0;
      if (wrd.latch_stb) begin
         if (!len_ok) begin
            st_d.drop = 1'b1;
         end else if (!tgt_top) begin
            // Companion chip traffic: mid bit is its payload, nothing here changes
            st_d.drop = 1'b0;
         end else begin
            case (tgt_code)
               twr_pkg::TGT_STATE: begin
                  // Parallel load of the whole field set
                  st_d.state_word = payload;
                  st_d.accept     = 1'b1;
                  // Only a transition into receive-on starts calibration
                  if (enter_rx_on) begin
                     st_d.cal_start = 1'b1;
                  end
               end
               twr_pkg::TGT_SETUP: begin
                  st_d.setup_word = payload;
                  st_d.accept     = 1'b1;
                  // Clear lands in the same cycle as the setup load
                  if (soft_clear) begin
                     st_d.state_word = twr_pkg::STATE_RST;
                  end
               end
               default: begin
                  st_d.drop = 1'b1;
               end
            endcase
         end
      end
   end

   // Setup word gets a defined value here even though software must still write it first
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_q.state_word <= twr_pkg::STATE_RST;
         st_q.setup_word <= twr_pkg::SETUP_RST;
         st_q.cal_start  <= 1'b0;
         st_q.accept     <= 1'b0;
         st_q.drop       <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // Band and mode outputs
   // ****************************************************************
   // Complementary enables: exactly one band path is ever on
   assign BAND_SEL_O              = st_q.state_word[twr_pkg::F_BAND];
   assign LOW_BAND_EN_O           = !st_q.state_word[twr_pkg::F_BAND];
   assign HIGH_BAND_EN_O          = st_q.state_word[twr_pkg::F_BAND];
   assign OP_STATE_O              = st_q.state_word[twr_pkg::F_OP_HI:twr_pkg::F_OP_LO];

   // ****************************************************************
   // Test disable outputs
   // ****************************************************************
   assign LO2_OFF_O               = st_q.state_word[twr_pkg::F_LO2_OFF];
   assign LO1_OFF_O               = st_q.state_word[twr_pkg::F_LO1_OFF];
   assign RX_DIV2_CORRECTOR_OFF_O = st_q.state_word[twr_pkg::F_RXDIV2_OFF];
   assign TX_DIV3_CORRECTOR_OFF_O = st_q.state_word[twr_pkg::F_TXDIV3_OFF];

   // ****************************************************************
   // Calibration outputs
   // ****************************************************************
   // The start pulse only asks; the calibration sequence itself runs outside
   assign LOWPASS_TUNE_REQUEST_O  = st_q.state_word[twr_pkg::F_LPF_TUNE];
   assign OFFSET_PRECHARGE_ONLY_O = st_q.state_word[twr_pkg::F_PRECHARGE];
   assign OFFSET_CAL_SKIP_O       = st_q.state_word[twr_pkg::F_CAL_SKIP];
   assign OFFSET_CAL_START_O      = st_q.cal_start;

   // ****************************************************************
   // Transmit IF divider outputs
   // ****************************************************************
   assign TX_IF_DIVIDER_SELECT_O  = st_q.state_word[twr_pkg::F_TXIF_DIVSEL];
   assign TX_DIV6_SELECT_O        = st_q.state_word[twr_pkg::F_TXDIV6];
   assign TX_IF_CORRECTOR_OFF_O   = st_q.state_word[twr_pkg::F_TXIF_CORR];

   // ****************************************************************
   // Gain outputs
   // ****************************************************************
   assign IF_GAIN_CODE_O          = st_q.state_word[twr_pkg::F_GAIN_HI:twr_pkg::F_GAIN_LO];
   assign LNA_SWITCH_O            = st_q.state_word[twr_pkg::F_LNA];

   // ****************************************************************
   // Raw registers and word status
   // ****************************************************************
   // Raw copies let the far side read back exactly what was latched
   assign RADIO_STATE_WORD_O      = st_q.state_word;
   assign SETUP_WORD_O            = st_q.setup_word;
   assign WORD_ACCEPT_O           = st_q.accept;
   assign WORD_DROP_O             = st_q.drop;

endmodule : twr_top

// *** dv/twr_asserts.sv ***
/* Checker for the radio control port, bound to twr_top.
   Assumes one system clock domain and the port names of twr_top. */
`timescale 1ns/1ps
module twr_asserts (
   // Clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   // Watched outputs
   input wire logic        BAND_SEL_O,
   input wire logic        LOW_BAND_EN_O,
   input wire logic [2:0]  OP_STATE_O,
   input wire logic        OFFSET_CAL_SKIP_O,
   input wire logic        OFFSET_CAL_START_O,
   input wire logic [5:0]  IF_GAIN_CODE_O,
   input wire logic        LNA_SWITCH_O,
   input wire logic [20:0] RADIO_STATE_WORD_O,
   input wire logic [20:0] SETUP_WORD_O,
   input wire logic        WORD_ACCEPT_O,
   input wire logic        WORD_DROP_O
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_band_inv;
      LOW_BAND_EN_O == !BAND_SEL_O;
   endproperty
   a_band_inv: assert property (p_band_inv) else $error("band enables wrong");
   property p_band_bit;
      BAND_SEL_O == RADIO_STATE_WORD_O[20];
   endproperty
   a_band_bit: assert property (p_band_bit) else $error("band bit wrong");
   property p_op_field;
      OP_STATE_O == RADIO_STATE_WORD_O[19:17];
   endproperty
   a_op_field: assert property (p_op_field) else $error("op state field wrong");
   property p_gain_field;
      {IF_GAIN_CODE_O, LNA_SWITCH_O} == RADIO_STATE_WORD_O[6:0];
   endproperty
   a_gain_field: assert property (p_gain_field) else $error("gain field wrong");
   property p_state_load;
      !$stable(RADIO_STATE_WORD_O) |-> WORD_ACCEPT_O && !WORD_DROP_O;
   endproperty
   a_state_load: assert property (p_state_load) else $error("state changed unloaded");
   property p_setup_load;
      !$stable(SETUP_WORD_O) |-> WORD_ACCEPT_O;
   endproperty
   a_setup_load: assert property (p_setup_load) else $error("setup changed unloaded");
   property p_cal_cause;
      OFFSET_CAL_START_O |-> OP_STATE_O == twr_pkg::OP_RX_ON && !OFFSET_CAL_SKIP_O
         && $past(OP_STATE_O) != twr_pkg::OP_RX_ON && WORD_ACCEPT_O;
   endproperty
   a_cal_cause: assert property (p_cal_cause) else $error("spurious cal start");
   property p_cal_entry;
      $changed(OP_STATE_O) && OP_STATE_O == twr_pkg::OP_RX_ON && !OFFSET_CAL_SKIP_O
         |-> OFFSET_CAL_START_O;
   endproperty
   a_cal_entry: assert property (p_cal_entry) else $error("cal start missing");
   property p_soft_clear;
      $changed(SETUP_WORD_O) && SETUP_WORD_O[twr_pkg::SETUP_RESET_POS]
         |-> RADIO_STATE_WORD_O == 21'h000000;
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("state not cleared");
   property p_pulse;
      WORD_ACCEPT_O |-> !WORD_DROP_O ##1 !WORD_ACCEPT_O;
   endproperty
   a_pulse: assert property (p_pulse) else $error("accept pulse wrong");
endmodule : twr_asserts

bind twr_top twr_asserts twr_asserts_i (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .BAND_SEL_O(BAND_SEL_O),
   .LOW_BAND_EN_O(LOW_BAND_EN_O), .OP_STATE_O(OP_STATE_O),
   .OFFSET_CAL_SKIP_O(OFFSET_CAL_SKIP_O), .OFFSET_CAL_START_O(OFFSET_CAL_START_O),
   .IF_GAIN_CODE_O(IF_GAIN_CODE_O), .LNA_SWITCH_O(LNA_SWITCH_O),
   .RADIO_STATE_WORD_O(RADIO_STATE_WORD_O), .SETUP_WORD_O(SETUP_WORD_O),
   .WORD_ACCEPT_O(WORD_ACCEPT_O), .WORD_DROP_O(WORD_DROP_O));

// *** dv/twr_ctrl_model.sv ***
/* Baseband controller model driving the three-wire bus, 320 ns bit time.
   Assumes the receiver samples the pins with its own clock. */
`timescale 1ns/1ps
module twr_ctrl_model (
   // Serial bus
   output logic sclk_o,
   output logic sdata_o,
   output logic latch_o
);
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      latch_o = 1'b0;
   end
   // Sends the n low bits of w; hi_latch breaks the bus rule on purpose
   // Callers start on a system clock edge, so every change lands by
   // non-blocking assignment on an edge and never races the samplers
   task automatic send(input logic [31:0] w, input int n, input bit hi_latch);
      for (int i = n - 1; i >= 0; i--) begin
         sdata_o <= w[i];
         #160 sclk_o <= 1'b1;
         #160 sclk_o <= hi_latch && (i == 0);
      end
      #80 latch_o <= 1'b1;
      #200 latch_o <= 1'b0;
      sclk_o <= 1'b0;
      // No pull on the data line, so a released line shows the inverse
      sdata_o <= ~sdata_o;
   endtask : send
endmodule : twr_ctrl_model

// *** dv/testbench.sv ***
/* Self-checking bench for twr_top: words go out through the controller model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module testbench;
   logic        sys_clk, rst_n, sclk, sdata, latch;
   logic        band, lowb, highb, lo2, lo1, rxd2, txd3, lpf, pre, skip, cal;
   logic        txsel, div6, txcorr, lna, acc, drop;
   logic [2:0]  op, prev_op;
   logic [5:0]  gain;
   logic [20:0] rsw, setup, cur;
   int          fail_count, n_compared, acc_n, drop_n, cal_n, cyc;
   logic [2:0]  op_seq [0:6] = '{twr_pkg::OP_SLEEP, twr_pkg::OP_TX_SETTLE,
      twr_pkg::OP_RX_SETTLE, twr_pkg::OP_TX_ON, twr_pkg::OP_RX_ON, twr_pkg::OP_RX_ON,
      twr_pkg::OP_SLEEP};

   twr_ctrl_model twr_ctrl_model_i (.sclk_o(sclk), .sdata_o(sdata), .latch_o(latch));
   twr_top twr_top_i (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .SER_CLK_I(sclk),
      .SER_DATA_I(sdata), .SER_LATCH_I(latch), .BAND_SEL_O(band), .LOW_BAND_EN_O(lowb),
      .HIGH_BAND_EN_O(highb), .OP_STATE_O(op), .LO2_OFF_O(lo2), .LO1_OFF_O(lo1),
      .RX_DIV2_CORRECTOR_OFF_O(rxd2), .TX_DIV3_CORRECTOR_OFF_O(txd3),
      .LOWPASS_TUNE_REQUEST_O(lpf), .OFFSET_PRECHARGE_ONLY_O(pre), .OFFSET_CAL_SKIP_O(skip),
      .OFFSET_CAL_START_O(cal), .TX_IF_DIVIDER_SELECT_O(txsel), .TX_DIV6_SELECT_O(div6),
      .TX_IF_CORRECTOR_OFF_O(txcorr), .IF_GAIN_CODE_O(gain), .LNA_SWITCH_O(lna),
      .RADIO_STATE_WORD_O(rsw), .SETUP_WORD_O(setup), .WORD_ACCEPT_O(acc),
      .WORD_DROP_O(drop));

   // ****************************************
   // Clock, pulse counters and hang guard
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      acc_n += (acc === 1'b1);
      drop_n += (drop === 1'b1);
      cal_n += (cal === 1'b1);
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One word on the bus; answer lands within 5 cycles, 12 gives margin
   task automatic xfer(input logic [31:0] w, input int n, input bit hl, input int ea,
                       input int ed);
      acc_n = 0;
      drop_n = 0;
      cal_n = 0;
      twr_ctrl_model_i.send(w, n, hl);
      repeat (12) @(posedge sys_clk);
      chk(acc_n, ea);
      chk(drop_n, ed);
      chk(rsw, cur);
   endtask : xfer

   task automatic st(input logic [20:0] p);
      logic exp_cal;
      exp_cal = (p[19:17] == twr_pkg::OP_RX_ON) && !p[10] && (prev_op != twr_pkg::OP_RX_ON);
      cur = p;
      xfer({1'b1, p, twr_pkg::TGT_STATE}, 24, 0, 1, 0);
      chk({band, op, lo2, lo1, rxd2, txd3, lpf, pre, skip, txsel, div6, txcorr, gain, lna},
          p);
      chk({lowb, highb}, {~p[20], p[20]});
      chk(cal_n, exp_cal);
      prev_op = p[19:17];
   endtask : st

   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      rst_n = 1'b0;
      cur = 21'h000000;
      prev_op = 3'h0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({rsw, setup, lowb}, 43'h1);
      xfer({1'b1, 21'h0abcde, twr_pkg::TGT_SETUP}, 24, 0, 1, 0);
      chk(setup, 21'h0abcde);
      $display("test setup done");
      st(21'h0d5a6b);
      st(21'h12a594);
      // Second receive-on entry is a rewrite and must not restart calibration
      for (int i = 0; i < 7; i++) begin
         st({1'b0, op_seq[i], 17'h00000});
      end
      st(21'h0e0400);
      $display("test modes done");
      xfer({1'b0, 21'h1fffff, 2'b10}, 24, 0, 0, 0);
      xfer({1'b1, 21'h1fffff, 2'b10}, 24, 0, 0, 1);
      xfer({1'b1, 21'h1fffff, 2'b11}, 24, 0, 0, 1);
      xfer({1'b1, 21'h1fffff, 2'b00}, 23, 0, 0, 1);
      xfer({1'b1, 21'h1fffff, 2'b00}, 25, 0, 0, 1);
      $display("test refusals done");
      xfer({1'b1, 21'h1fffff, 2'b00}, 24, 1, 0, 0);
      xfer({1'b1, 21'h1fffff, 2'b00}, 24, 0, 0, 1);
      st(21'h0f0001);
      $display("test latch done");
      cur = 21'h000000;
      // No calibration is running here, so rewriting the setup word is allowed
      xfer({1'b1, 21'h100000, twr_pkg::TGT_SETUP}, 24, 0, 1, 0);
      chk(setup, 21'h100000);
      prev_op = 3'h0;
      st(21'h0e0000);
      $display("test soft reset done");
      complete_run();
   end
endmodule : testbench
